// ### sync_ctl_pkg.sv
// Register map, field positions, reset values and timing for the sync, coast and clamp control
package sync_ctl_pkg;

    localparam logic [7:0] ADDR_VSYNC_SRC = 8'h0e;
    localparam logic [7:0] ADDR_CLAMP_COAST = 8'h0f;
    localparam logic [7:0] ADDR_GREEN_THR = 8'h10;
    localparam logic [7:0] ADDR_SEP_THR = 8'h11;
    localparam logic [7:0] ADDR_LEAD = 8'h12;
    localparam logic [7:0] ADDR_TRAIL = 8'h13;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    localparam logic [1:0] RST_VSYNC_SRC = 2'h0;
    localparam logic [7:0] RST_CLAMP_COAST = 8'h4e;
    localparam logic [7:0] RST_GREEN_THR = 8'hb8;
    localparam logic [7:0] RST_SEP_THR = 8'h20;
    localparam logic [7:0] RST_LEAD = 8'h00;
    localparam logic [7:0] RST_TRAIL = 8'h00;

    // Vertical source control
    localparam int VS_OVR_BIT = 1;
    localparam int VS_SEL_BIT = 0;
    // Clamp, coast and power control
    localparam int CLAMP_SRC_BIT = 7;
    localparam int CLAMP_POL_BIT = 6;
    localparam int COAST_SRC_BIT = 5;
    localparam int COAST_OVR_BIT = 4;
    localparam int COAST_POL_BIT = 3;
    localparam int SEEK_BIT = 2;
    localparam int FULL_POWER_DOWN_N_BIT = 1;
    // Green threshold and clamp selects
    localparam int THR_MSB = 7;
    localparam int THR_LSB = 3;
    localparam int MID_MSB = 2;
    localparam int MID_LSB = 0;

    // Input pin positions in the synchroniser vector
    localparam int PIN_HS = 0;
    localparam int PIN_VS = 1;
    localparam int PIN_SOG = 2;
    localparam int PIN_COAST = 3;
    localparam int PIN_CLAMP = 4;
    localparam int NUM_PINS = 5;
    // Level each pin rests at through reset; green sync idles high
    localparam logic [NUM_PINS-1:0] PIN_REST = 5'h04;

    localparam int CLK_HZ = 250_000_000;
    localparam int SEP_CLK_HZ = 5_000_000;
    localparam logic [5:0] TICK_LAST = 6'(CLK_HZ / SEP_CLK_HZ - 1);

endpackage : sync_ctl_pkg

// ### sync_coast_clamp_control.sv
// Sync source selection, sync separator, coast and clamp generation with their register bank
// How it works
// - Vsync override set: user select picks output vsync; clear: automatic choice.
// - Vsync select: zero routes raw vsync, one routes separator vsync, under override.
// - Clamp source zero uses internal hsync timing, one the external clamp input.
// - Clamp polarity for external clamp: zero active high, one active low.
// - Coast source zero uses coast pin, one derives coast from vsync.
// - Coast polarity override zero: detected polarity; one: programmed polarity bit.
// - Coast polarity bit: zero active low, one active high.
// - Seek override one allows low-power mode, zero forbids it.
// - Power-down bit active low: zero powers chip down, one normal.
// - Five-bit green threshold field drives the slicer comparator trip level.
// - Per-channel clamp selects: zero clamps to ground, one to midscale.
// - Separator counts 5 MHz periods up to threshold before toggling output.
// - Coast rises the programmed number of lines before vsync starts.
// - Coast stays high the programmed number of lines after vsync.
// - Status bit 7 reads one while hsync is present.
// - Status bit 6: zero hsync pin in use, one green-channel sync.
// - Status bit 5 reports detected input hsync polarity, one active high.
// - Status bit 4 reads one while vsync is present.
// - Status bit 3: zero vsync pin in use, one separator vsync.
// - Status bit 2 reports detected output vsync polarity, one active high.
// - Status bit 1 reads one while sync is seen on green.
// - Status bit 0 reports detected coast input polarity, one active high.
`timescale 1ns/1ps
`default_nettype none

module sync_coast_clamp_control #(
    parameter int ACT_W = 20,
    parameter int HS_TIMEOUT_TICKS = 1024,
    parameter int VS_TIMEOUT_TICKS = 500000,
    parameter int POL_W = 8,
    parameter int LINE_W = 12
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_hsync,
    input wire logic i_vsync,
    input wire logic i_green_sync,
    input wire logic i_coast,
    input wire logic i_clamp,
    output logic o_vsync,
    output logic o_clamp,
    output logic o_coast,
    output logic [4:0] o_green_sync_threshold,
    output logic [2:0] o_clamp_midscale,
    output logic o_power_down,
    output logic o_low_power
);

    typedef struct packed {
        logic [sync_ctl_pkg::NUM_PINS-1:0] meta;
        logic [sync_ctl_pkg::NUM_PINS-1:0] pin;
        logic [sync_ctl_pkg::NUM_PINS-1:0] pin_prev;
        logic [1:0] vsync_source_control;
        logic [7:0] clamp_coast_power_control;
        logic [7:0] green_sync_threshold_clamp_select;
        logic [7:0] separator_count_threshold;
        logic [7:0] coast_lead_lines;
        logic [7:0] coast_trail_lines;
        logic [5:0] div_cnt;
        logic [7:0] sep_cnt;
        logic sep_out;
        logic [ACT_W-1:0] hs_act;
        logic [ACT_W-1:0] vs_act;
        logic [ACT_W-1:0] sog_act;
        logic [POL_W-1:0] hs_pol;
        logic [POL_W-1:0] vs_pol;
        logic [POL_W-1:0] co_pol;
        logic hs_norm;
        logic vs_norm;
        logic [LINE_W-1:0] line_cnt;
        logic [LINE_W-1:0] frame_len;
        logic [7:0] post_cnt;
        logic [7:0] rdata;
        logic vsync_out;
        logic clamp_out;
        logic coast_out;
    } state_t;

    localparam logic [ACT_W-1:0] HS_LIMIT = ACT_W'(HS_TIMEOUT_TICKS);
    localparam logic [ACT_W-1:0] VS_LIMIT = ACT_W'(VS_TIMEOUT_TICKS);
    localparam logic [POL_W-1:0] POL_MID = {1'b1, {(POL_W-1){1'b0}}};

    state_t st_q;
    state_t st_d;

    logic tick;
    logic [sync_ctl_pkg::NUM_PINS-1:0] edges;
    logic hs_present;
    logic vs_present;
    logic sog_present;
    logic hs_pol_high;
    logic vs_pol_high;
    logic co_pol_high;
    logic active_hsync_source;
    logic active_vsync_source;
    logic vsel;
    logic hs_norm;
    logic vs_norm;
    logic sep_active;
    logic sep_hit;
    logic line_edge;
    logic coast_from_vs;
    logic coast_pol_high;
    logic coast_from_pin;
    logic clamp_next;
    logic coast_next;
    logic power_down;
    logic [LINE_W:0] lead_sum;
    logic [7:0] status;

    // Activity timeout: any edge restarts it, running out means no sync
    function automatic logic [ACT_W-1:0] act_next(input logic [ACT_W-1:0] cnt,
                                                  input logic seen, input logic tk,
                                                  input logic [ACT_W-1:0] limit);
        logic [ACT_W-1:0] r;
        r = cnt;
        if (seen) begin
            r = '0;
        end else if (tk && cnt < limit) begin
            r = cnt + ACT_W'(1);
        end
        return r;
    endfunction : act_next

    // Level balance: a mostly-low signal has active high pulses
    function automatic logic [POL_W-1:0] pol_next(input logic [POL_W-1:0] cnt,
                                                  input logic level, input logic tk);
        logic [POL_W-1:0] r;
        r = cnt;
        if (tk && level && cnt != '1) begin
            r = cnt + POL_W'(1);
        end else if (tk && !level && cnt != '0) begin
            r = cnt - POL_W'(1);
        end
        return r;
    endfunction : pol_next

    always_comb begin
        st_d = st_q;
        st_d.meta = {i_clamp, i_coast, i_green_sync, i_vsync, i_hsync};
        st_d.pin = st_q.meta;
        st_d.pin_prev = st_q.pin;
        edges = st_q.pin ^ st_q.pin_prev;

        tick = (st_q.div_cnt == sync_ctl_pkg::TICK_LAST);
        st_d.div_cnt = tick ? 6'h00 : st_q.div_cnt + 6'h01;

        st_d.hs_act = act_next(st_q.hs_act, edges[sync_ctl_pkg::PIN_HS], tick, HS_LIMIT);
        st_d.vs_act = act_next(st_q.vs_act, edges[sync_ctl_pkg::PIN_VS], tick, VS_LIMIT);
        st_d.sog_act = act_next(st_q.sog_act, edges[sync_ctl_pkg::PIN_SOG], tick, HS_LIMIT);
        hs_present = st_q.hs_act < HS_LIMIT;
        vs_present = st_q.vs_act < VS_LIMIT;
        sog_present = st_q.sog_act < HS_LIMIT;

        st_d.hs_pol = pol_next(st_q.hs_pol, st_q.pin[sync_ctl_pkg::PIN_HS], tick);
        st_d.co_pol = pol_next(st_q.co_pol, st_q.pin[sync_ctl_pkg::PIN_COAST], tick);
        hs_pol_high = st_q.hs_pol < POL_MID;
        co_pol_high = st_q.co_pol < POL_MID;

        // Green-channel sync wins only when the hsync pin is silent
        active_hsync_source = !hs_present && sog_present;
        hs_norm = active_hsync_source ? !st_q.pin[sync_ctl_pkg::PIN_SOG]
                      : (hs_pol_high ? st_q.pin[sync_ctl_pkg::PIN_HS]
                                     : !st_q.pin[sync_ctl_pkg::PIN_HS]);
        st_d.hs_norm = hs_norm;
        line_edge = hs_norm && !st_q.hs_norm;

        // Separator works on the composite sync carried on green, active low
        sep_active = !st_q.pin[sync_ctl_pkg::PIN_SOG];
        sep_hit = tick && (sep_active != st_q.sep_out)
                  && (st_q.sep_cnt >= st_q.separator_count_threshold);
        if (sep_hit) begin
            st_d.sep_out = !st_q.sep_out;
            st_d.sep_cnt = 8'h00;
        end else if (sep_active == st_q.sep_out) begin
            st_d.sep_cnt = 8'h00;
        end else if (tick && st_q.sep_cnt != 8'hff) begin
            st_d.sep_cnt = st_q.sep_cnt + 8'h01;
        end

        if (st_q.vsync_source_control[sync_ctl_pkg::VS_OVR_BIT]) begin
            active_vsync_source = st_q.vsync_source_control[sync_ctl_pkg::VS_SEL_BIT];
        end else begin
            active_vsync_source = !vs_present;
        end
        vsel = active_vsync_source ? st_q.sep_out : st_q.pin[sync_ctl_pkg::PIN_VS];
        st_d.vs_pol = pol_next(st_q.vs_pol, vsel, tick);
        vs_pol_high = st_q.vs_pol < POL_MID;
        vs_norm = active_vsync_source ? st_q.sep_out : (vs_pol_high ? vsel : !vsel);
        st_d.vs_norm = vs_norm;

        // Frame length is learned at each vsync so the lead window can be predicted
        if (vs_norm && !st_q.vs_norm) begin
            st_d.frame_len = st_q.line_cnt;
            st_d.line_cnt = '0;
        end else if (line_edge && st_q.line_cnt != '1) begin
            st_d.line_cnt = st_q.line_cnt + LINE_W'(1);
        end
        if (!vs_norm && st_q.vs_norm) begin
            st_d.post_cnt = 8'h00;
        end else if (line_edge && st_q.post_cnt != 8'hff) begin
            st_d.post_cnt = st_q.post_cnt + 8'h01;
        end
        lead_sum = {1'b0, st_q.line_cnt} + (LINE_W + 1)'(st_q.coast_lead_lines);
        coast_from_vs = st_q.vs_norm
                        || (st_q.post_cnt < st_q.coast_trail_lines)
                        || (st_q.frame_len != '0
                            && lead_sum >= {1'b0, st_q.frame_len});

        if (st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_OVR_BIT]) begin
            coast_pol_high = st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_POL_BIT];
        end else begin
            coast_pol_high = co_pol_high;
        end
        coast_from_pin = coast_pol_high ? st_q.pin[sync_ctl_pkg::PIN_COAST]
                                        : !st_q.pin[sync_ctl_pkg::PIN_COAST];
        coast_next = st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_SRC_BIT]
                     ? coast_from_vs : coast_from_pin;

        if (st_q.clamp_coast_power_control[sync_ctl_pkg::CLAMP_SRC_BIT]) begin
            clamp_next = st_q.pin[sync_ctl_pkg::PIN_CLAMP]
                         ^ st_q.clamp_coast_power_control[sync_ctl_pkg::CLAMP_POL_BIT];
        end else begin
            clamp_next = hs_norm;
        end

        // Powered down the sync outputs rest low; the register port keeps working
        power_down = !st_q.clamp_coast_power_control[sync_ctl_pkg::FULL_POWER_DOWN_N_BIT];
        st_d.vsync_out = !power_down && vsel;
        st_d.clamp_out = !power_down && clamp_next;
        st_d.coast_out = !power_down && coast_next;

        status = {hs_present, active_hsync_source, hs_pol_high, vs_present,
                  active_vsync_source, vs_pol_high, sog_present, co_pol_high};

        if (i_reg_wr) begin
            if (i_reg_addr == sync_ctl_pkg::ADDR_VSYNC_SRC) begin
                st_d.vsync_source_control = i_reg_wdata[1:0];
            end else if (i_reg_addr == sync_ctl_pkg::ADDR_CLAMP_COAST) begin
                st_d.clamp_coast_power_control = {i_reg_wdata[7:1], 1'b0};
            end else if (i_reg_addr == sync_ctl_pkg::ADDR_GREEN_THR) begin
                st_d.green_sync_threshold_clamp_select = i_reg_wdata;
            end else if (i_reg_addr == sync_ctl_pkg::ADDR_SEP_THR) begin
                st_d.separator_count_threshold = i_reg_wdata;
            end else if (i_reg_addr == sync_ctl_pkg::ADDR_LEAD) begin
                st_d.coast_lead_lines = i_reg_wdata;
            end else if (i_reg_addr == sync_ctl_pkg::ADDR_TRAIL) begin
                st_d.coast_trail_lines = i_reg_wdata;
            end
        end

        if (i_reg_addr == sync_ctl_pkg::ADDR_VSYNC_SRC) begin
            st_d.rdata = {6'h00, st_q.vsync_source_control};
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_CLAMP_COAST) begin
            st_d.rdata = st_q.clamp_coast_power_control;
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_GREEN_THR) begin
            st_d.rdata = st_q.green_sync_threshold_clamp_select;
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_SEP_THR) begin
            st_d.rdata = st_q.separator_count_threshold;
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_LEAD) begin
            st_d.rdata = st_q.coast_lead_lines;
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_TRAIL) begin
            st_d.rdata = st_q.coast_trail_lines;
        end else if (i_reg_addr == sync_ctl_pkg::ADDR_STATUS) begin
            st_d.rdata = status;
        end else begin
            st_d.rdata = 8'h00;
        end

        if (!i_reset_n) begin
            st_d = '0;
            // Chain preloaded with idle levels so release shows no false pin edge
            st_d.meta = sync_ctl_pkg::PIN_REST;
            st_d.pin = sync_ctl_pkg::PIN_REST;
            st_d.pin_prev = sync_ctl_pkg::PIN_REST;
            st_d.vsync_source_control = sync_ctl_pkg::RST_VSYNC_SRC;
            st_d.clamp_coast_power_control = sync_ctl_pkg::RST_CLAMP_COAST;
            st_d.green_sync_threshold_clamp_select = sync_ctl_pkg::RST_GREEN_THR;
            st_d.separator_count_threshold = sync_ctl_pkg::RST_SEP_THR;
            st_d.coast_lead_lines = sync_ctl_pkg::RST_LEAD;
            st_d.coast_trail_lines = sync_ctl_pkg::RST_TRAIL;
            st_d.hs_act = HS_LIMIT;
            st_d.vs_act = VS_LIMIT;
            st_d.sog_act = HS_LIMIT;
            st_d.hs_pol = POL_MID;
            st_d.vs_pol = POL_MID;
            st_d.co_pol = POL_MID;
            st_d.post_cnt = 8'hff;
        end
    end

    always_ff @(posedge i_clk) begin
        st_q <= st_d;
    end

    assign o_reg_rdata = st_q.rdata;
    assign o_vsync = st_q.vsync_out;
    assign o_clamp = st_q.clamp_out;
    assign o_coast = st_q.coast_out;
    assign o_green_sync_threshold =
        st_q.green_sync_threshold_clamp_select[sync_ctl_pkg::THR_MSB:sync_ctl_pkg::THR_LSB];
    assign o_clamp_midscale =
        st_q.green_sync_threshold_clamp_select[sync_ctl_pkg::MID_MSB:sync_ctl_pkg::MID_LSB];
    assign o_power_down = power_down;
    // Low power only when allowed and no sync of any kind is seen
    assign o_low_power = st_q.clamp_coast_power_control[sync_ctl_pkg::SEEK_BIT]
                         && !hs_present && !vs_present && !sog_present;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    AST_VS_OVERRIDE: assert property (
        st_q.vsync_source_control[sync_ctl_pkg::VS_OVR_BIT]
        |-> active_vsync_source == st_q.vsync_source_control[sync_ctl_pkg::VS_SEL_BIT])
        else $error("Override did not pick the user vsync source");

    AST_VS_ROUTE: assert property (
        (active_vsync_source && !power_down) |=> o_vsync == $past(st_q.sep_out))
        else $error("Separator vsync not routed");

    AST_CLAMP_EXT: assert property (
        (st_q.clamp_coast_power_control[sync_ctl_pkg::CLAMP_SRC_BIT] && !power_down)
        |=> o_clamp == ($past(st_q.pin[sync_ctl_pkg::PIN_CLAMP])
                        ^ $past(st_q.clamp_coast_power_control[sync_ctl_pkg::CLAMP_POL_BIT])))
        else $error("External clamp polarity wrong");

    AST_COAST_PIN: assert property (
        (!st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_SRC_BIT] && !power_down
         && coast_pol_high && st_q.pin[sync_ctl_pkg::PIN_COAST]) |=> o_coast)
        else $error("Active high coast pin not followed");

    AST_POWER_DOWN: assert property (
        power_down [*2] |-> !o_vsync && !o_clamp && !o_coast)
        else $error("Outputs active during power down");

    AST_THRESH_WRITE: assert property (
        (i_reg_wr && i_reg_addr == sync_ctl_pkg::ADDR_GREEN_THR)
        |=> ##1 o_green_sync_threshold
            == $past(i_reg_wdata[sync_ctl_pkg::THR_MSB:sync_ctl_pkg::THR_LSB], 2))
        else $error("Green threshold field not applied");

    AST_SEP_TOGGLE: assert property (
        $changed(st_q.sep_out) |-> $past(sep_hit))
        else $error("Separator toggled before threshold");

    AST_TRAIL: assert property (
        (st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_SRC_BIT] && !power_down
         && st_q.post_cnt < st_q.coast_trail_lines) |=> o_coast)
        else $error("Coast dropped inside trailing window");

    AST_STATUS_READ: assert property (
        (i_reg_addr == sync_ctl_pkg::ADDR_STATUS) |=> o_reg_rdata[7] == $past(hs_present))
        else $error("Hsync present flag misreported");

    AST_SEEK: assert property (
        o_low_power |-> st_q.clamp_coast_power_control[sync_ctl_pkg::SEEK_BIT])
        else $error("Low power entered while forbidden");

    AST_CLAMP_INT: assert property (
        (i_reset_n && !st_q.clamp_coast_power_control[sync_ctl_pkg::CLAMP_SRC_BIT] && !power_down)
        |=> o_clamp == $past(hs_norm))
        else $error("Internal clamp does not follow hsync");

    AST_COAST_VS: assert property (
        (i_reset_n && st_q.clamp_coast_power_control[sync_ctl_pkg::COAST_SRC_BIT] && !power_down)
        |=> o_coast == $past(coast_from_vs))
        else $error("Coast not derived from vsync");

endmodule : sync_coast_clamp_control

`default_nettype wire

// ### video_source.sv
// Behavioural video source driving periodic hsync and vsync pins
`timescale 1ns/1ps
`default_nettype none

module video_source (
    input wire logic i_clk,
    input wire logic i_run,
    output logic o_hsync,
    output logic o_vsync
);
    // Line of 400 clocks is 8 separator ticks, inside the shortened hsync timeout
    logic [8:0] pix_q;
    logic [2:0] line_q;

    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            pix_q <= 9'h000;
            line_q <= 3'h0;
        end else if (pix_q == 9'd399) begin
            pix_q <= 9'h000;
            line_q <= (line_q == 3'h5) ? 3'h0 : line_q + 3'h1;
        end else begin
            pix_q <= pix_q + 9'h001;
        end
    end

    // Pins sit low when stopped so the presence timers run out
    assign o_hsync = i_run && (pix_q < 9'd20);
    assign o_vsync = i_run && (line_q == 3'h0);
endmodule : video_source

`default_nettype wire

// ### tb_sync_coast_clamp_control.sv
// Self-checking testbench for the sync, coast and clamp control block
`timescale 1ns/1ps
`default_nettype none

module tb_sync_coast_clamp_control;
    logic i_clk, i_reset_n, i_reg_wr, i_green_sync, i_coast, i_clamp, run;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, vs_hist, r;
    logic i_hsync, i_vsync, o_vsync, o_clamp, o_coast, o_power_down, o_low_power;
    logic [4:0] o_green_sync_threshold;
    logic [2:0] o_clamp_midscale;
    int mismatches = 0;
    int n_tests = 0;

    sync_coast_clamp_control #(.HS_TIMEOUT_TICKS(16), .VS_TIMEOUT_TICKS(64))
    sync_coast_clamp_control_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_hsync(i_hsync), .i_vsync(i_vsync), .i_green_sync(i_green_sync),
        .i_coast(i_coast), .i_clamp(i_clamp), .o_vsync(o_vsync), .o_clamp(o_clamp),
        .o_coast(o_coast), .o_green_sync_threshold(o_green_sync_threshold),
        .o_clamp_midscale(o_clamp_midscale), .o_power_down(o_power_down),
        .o_low_power(o_low_power)
    );

    video_source video_source_inst (
        .i_clk(i_clk), .i_run(run), .o_hsync(i_hsync), .o_vsync(i_vsync)
    );

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    always @(posedge i_clk) vs_hist <= {vs_hist[6:0], i_vsync};

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        @(posedge i_clk);
        #1 d = o_reg_rdata;
    endtask : rd

    // Lets a pin change cross the synchronisers and output flops
    task automatic settle();
        repeat (6) @(posedge i_clk);
        #1;
    endtask : settle

    task automatic t_reset();
        rd(sync_ctl_pkg::ADDR_VSYNC_SRC, r);
        check(r, 8'h00);
        rd(sync_ctl_pkg::ADDR_CLAMP_COAST, r);
        check(r, sync_ctl_pkg::RST_CLAMP_COAST);
        rd(sync_ctl_pkg::ADDR_GREEN_THR, r);
        check(r, sync_ctl_pkg::RST_GREEN_THR);
        rd(sync_ctl_pkg::ADDR_SEP_THR, r);
        check(r, sync_ctl_pkg::RST_SEP_THR);
        rd(sync_ctl_pkg::ADDR_LEAD, r);
        check(r, sync_ctl_pkg::RST_LEAD);
        rd(sync_ctl_pkg::ADDR_TRAIL, r);
        check(r, sync_ctl_pkg::RST_TRAIL);
        check({3'h0, o_green_sync_threshold}, 8'h17);
        check({5'h0, o_clamp_midscale}, 8'h00);
        check({7'h0, o_power_down}, 8'h00);
        check({7'h0, o_low_power}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr(sync_ctl_pkg::ADDR_SEP_THR, 8'h40);
        rd(sync_ctl_pkg::ADDR_SEP_THR, r);
        check(r, 8'h40);
        wr(sync_ctl_pkg::ADDR_LEAD, 8'hff);
        wr(sync_ctl_pkg::ADDR_TRAIL, 8'h01);
        rd(sync_ctl_pkg::ADDR_LEAD, r);
        check(r, 8'hff);
        rd(sync_ctl_pkg::ADDR_TRAIL, r);
        check(r, 8'h01);
        wr(sync_ctl_pkg::ADDR_VSYNC_SRC, 8'hff);
        rd(sync_ctl_pkg::ADDR_VSYNC_SRC, r);
        check(r, 8'h03);
        wr(8'h40, 8'h5a);
        rd(8'h40, r);
        check(r, 8'h00);
        wr(sync_ctl_pkg::ADDR_GREEN_THR, 8'h5d);
        settle();
        check({3'h0, o_green_sync_threshold}, 8'h0b);
        check({5'h0, o_clamp_midscale}, 8'h05);
        wr(sync_ctl_pkg::ADDR_VSYNC_SRC, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_clamp();
        logic a;
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h8e);
        i_clamp <= 1'b1;
        settle();
        check({7'h0, o_clamp}, 8'h01);
        @(posedge i_clk) i_clamp <= 1'b0;
        settle();
        check({7'h0, o_clamp}, 8'h00);
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'hce);
        settle();
        check({7'h0, o_clamp}, 8'h01);
        // Internal source must ignore the clamp pin whatever its level
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h0e);
        settle();
        a = o_clamp;
        @(posedge i_clk) i_clamp <= 1'b1;
        settle();
        check({7'h0, o_clamp}, {7'h0, a});
        @(posedge i_clk) i_clamp <= 1'b0;
        $display("test clamp done");
    endtask : t_clamp

    task automatic t_coast();
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h1a);
        i_coast <= 1'b1;
        settle();
        check({7'h0, o_coast}, 8'h01);
        check({7'h0, o_low_power}, 8'h00);
        @(posedge i_clk) i_coast <= 1'b0;
        settle();
        check({7'h0, o_coast}, 8'h00);
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h12);
        settle();
        check({7'h0, o_coast}, 8'h01);
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h10);
        settle();
        check({7'h0, o_power_down}, 8'h01);
        check({7'h0, o_coast}, 8'h00);
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, sync_ctl_pkg::RST_CLAMP_COAST);
        settle();
        check({7'h0, o_power_down}, 8'h00);
        $display("test coast done");
    endtask : t_coast

    task automatic t_sync();
        @(posedge i_clk) run <= 1'b1;
        repeat (1000) @(posedge i_clk);
        rd(sync_ctl_pkg::ADDR_STATUS, r);
        check({7'h0, r[7]}, 8'h01);
        check({7'h0, r[6]}, 8'h00);
        check({7'h0, r[4]}, 8'h01);
        check({7'h0, r[3]}, 8'h00);
        check({7'h0, r[5]}, 8'h01);
        check({7'h0, r[2]}, 8'h01);
        check({7'h0, r[1]}, 8'h00);
        check({7'h0, r[0]}, 8'h01);
        #1 check({7'h0, o_low_power}, 8'h00);
        wr(sync_ctl_pkg::ADDR_VSYNC_SRC, 8'h02);
        // Compare only where the pin has been steady longer than the path delay
        repeat (3000) begin
            @(posedge i_clk);
            #1;
            if (vs_hist == 8'h00 || vs_hist == 8'hff) check({7'h0, o_vsync}, {7'h0, vs_hist[0]});
        end
        wr(sync_ctl_pkg::ADDR_CLAMP_COAST, 8'h6e);
        settle();
        // Lead of 255 lines spans the whole six-line frame, so coast stays up
        check({7'h0, o_coast}, 8'h01);
        @(posedge i_clk) run <= 1'b0;
        repeat (4000) @(posedge i_clk);
        rd(sync_ctl_pkg::ADDR_STATUS, r);
        check({7'h0, r[7]}, 8'h00);
        check({7'h0, r[4]}, 8'h00);
        $display("test sync done");
    endtask : t_sync

    task automatic t_sep();
        wr(sync_ctl_pkg::ADDR_SEP_THR, 8'h04);
        wr(sync_ctl_pkg::ADDR_VSYNC_SRC, 8'h03);
        // A 100-cycle low is shorter than four ticks and must not toggle
        i_green_sync <= 1'b0;
        repeat (100) @(posedge i_clk);
        i_green_sync <= 1'b1;
        settle();
        check({7'h0, o_vsync}, 8'h00);
        @(posedge i_clk) i_green_sync <= 1'b0;
        repeat (400) @(posedge i_clk);
        #1 check({7'h0, o_vsync}, 8'h01);
        rd(sync_ctl_pkg::ADDR_STATUS, r);
        check({7'h0, r[6]}, 8'h01);
        check({7'h0, r[3]}, 8'h01);
        check({7'h0, r[1]}, 8'h01);
        @(posedge i_clk) i_green_sync <= 1'b1;
        repeat (400) @(posedge i_clk);
        #1 check({7'h0, o_vsync}, 8'h00);
        $display("test separator done");
    endtask : t_sep

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        // Tests need about 10,000 cycles; this leaves more than twice that
        #100000;
        mismatches++;
        final_report();
    end

    initial begin
        i_reset_n = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_green_sync = 1'b1;
        i_coast = 1'b0;
        i_clamp = 1'b0;
        run = 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_clamp();
        t_coast();
        t_sync();
        t_sep();
        final_report();
    end
endmodule : tb_sync_coast_clamp_control

`default_nettype wire
